// ---- design/pdct_defines.vh ----
// constants for the panel driver control pulse timing block
`ifndef PDCT_DEFINES_VH
`define PDCT_DEFINES_VH
`define PDCT_ADDR_PWR_DLY 8'h00
`define PDCT_ADDR_GCK_DLY 8'h04
`define PDCT_ADDR_LAT_W 8'h08
`define PDCT_ADDR_GCK_RISE 8'h0c
`define PDCT_ADDR_GCK_FALL 8'h10
`define PDCT_ADDR_OE_FIRST 8'h14
`define PDCT_ADDR_OE_SECOND 8'h18
`define PDCT_ADDR_FMT2 8'h1c
`define PDCT_ADDR_LINE_LEN 8'h20
`define PDCT_ADDR_STATUS 8'h24
`define PDCT_RST_PWR_DLY 5'h01
`define PDCT_RST_GCK_DLY 5'h02
`define PDCT_RST_LAT_W 6'h05
`define PDCT_RST_GCK_RISE 8'ha5
`define PDCT_RST_GCK_FALL 8'h2f
`define PDCT_RST_OE_FIRST 8'h05
`define PDCT_RST_OE_SECOND 8'hb4
`define PDCT_RST_FMT2 1'h1
`define PDCT_RST_LINE_LEN 12'h190
`define PDCT_RST_TRES_DIV 8'h08
`define PDCT_STEP_MS 5
`define PDCT_CLK_KHZ 125000
`define PDCT_STEP_CYC (`PDCT_STEP_MS * `PDCT_CLK_KHZ)
`define PDCT_DIR_BIT 7
`define PDCT_OFS_MSB 6
`define PDCT_DLY_MSB 4
`define PDCT_LAT_MSB 5
`define PDCT_EDGE_MSB 7
`define PDCT_POL_BIT 0
`define PDCT_DIV_LSB 8
`define PDCT_DIV_MSB 15
`define PDCT_LEN_MSB 11
`define PDCT_ANCHOR 13'h0080
`define PDCT_MS_SAT 6'h3f
`endif

// ---- design/pdct_timing.v ----
// control pulse timing generator for gate and source drivers, with apb registers
// Function
// - power transition output rises after power-delay field times 5 ms from reset release.
// - gate shift clock pulses start after start-delay field times 5 ms.
// - source latch pulse lasts 1 to 63 timing units per six-bit field.
// - gate shift clock rises at seven-bit offset from latch rising edge.
// - gate shift clock falls at seven-bit offset from latch rising edge.
// - bit 7 of each edge register selects after (0) or before (1) latch edge.
// - first enable register sets enable fall if polarity is 1, else rise.
// - second enable register sets enable rise if polarity is 1, else fall.
// - each enable edge is placed 0 to 127 units from latch rising edge.
// - equal enable registers give no edges; enable holds the polarity level.
// - enable polarity comes from bit 0 of the format control register.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pdct_defines.vh"
module pdct_timing #(
    parameter STEP_CYC = `PDCT_STEP_CYC
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    output reg power_step_o,
    output reg source_latch_pulse_o,
    output reg gate_shift_clock_o,
    output reg gate_enable_o
);
    // configuration registers and their next values
    reg [4:0] pwr_dly_r;
    reg [4:0] pwr_dly_nxt;
    reg [4:0] gck_dly_r;
    reg [4:0] gck_dly_nxt;
    reg [5:0] lat_w_r;
    reg [5:0] lat_w_nxt;
    reg [7:0] gck_rise_r;
    reg [7:0] gck_rise_nxt;
    reg [7:0] gck_fall_r;
    reg [7:0] gck_fall_nxt;
    reg [7:0] oe_first_r;
    reg [7:0] oe_first_nxt;
    reg [7:0] oe_second_r;
    reg [7:0] oe_second_nxt;
    reg oe_pol_r;
    reg oe_pol_nxt;
    reg [11:0] line_len_r;
    reg [11:0] line_len_nxt;
    reg [7:0] tres_div_r;
    reg [7:0] tres_div_nxt;

    // time base and line position
    reg [22:0] step_cnt_r;
    reg [22:0] step_cnt_nxt;
    reg [5:0] ms_steps_r;
    reg [5:0] ms_steps_nxt;
    reg [7:0] tres_cnt_r;
    reg [7:0] tres_cnt_nxt;
    reg tick_r;
    reg tick_nxt;
    reg [11:0] pos_r;
    reg [11:0] pos_nxt;
    reg gck_run_r;
    reg gck_run_nxt;
    reg power_step_nxt;

    // pulse output and bus next values
    reg latch_nxt;
    reg gck_nxt;
    reg oe_nxt;
    reg [31:0] rd_nxt;
    reg hit_nxt;
    reg ready_nxt;
    reg slverr_nxt;
    reg [31:0] prdata_nxt;
    wire setup = psel_i & ~penable_i;
    // writes land at the access edge, where the master sees pready high
    wire wr = psel_i & penable_i & pready_o & pwrite_i;
    wire [12:0] anchor = `PDCT_ANCHOR;
    wire [12:0] cur = {1'b0, pos_r};
    wire [12:0] lat_end = anchor + {7'h00, lat_w_r};
    wire oe_same = (oe_first_r == oe_second_r);
    wire step_end = ({9'h000, step_cnt_r} == STEP_CYC - 1);
    wire unit_end = (tres_cnt_r >= tres_div_r - 8'h01);
    wire line_end = (pos_r >= line_len_r - 12'h001);
    wire ms_sat = (ms_steps_r == `PDCT_MS_SAT);
    wire [31:0] fmt_word = {16'h0000, tres_div_r, 7'h00, oe_pol_r};
    wire [31:0] status_word = {18'h00000, ms_steps_r, 5'h00, gck_run_r, gate_shift_clock_o, power_step_o};
    wire [7:0] edge_cfg [0:3];
    wire [12:0] edge_pos [0:3];
    wire [3:0] edge_hit;
    genvar gi;

    // one entry per edge: gate clock rise, gate clock fall, enable first, enable second
    assign edge_cfg[0] = gck_rise_r;
    assign edge_cfg[1] = gck_fall_r;
    assign edge_cfg[2] = oe_first_r;
    assign edge_cfg[3] = oe_second_r;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_edge
            // limitation: line length must exceed anchor plus 127 units
            assign edge_pos[gi] = edge_cfg[gi][`PDCT_DIR_BIT] ?
                anchor - {6'h00, edge_cfg[gi][`PDCT_OFS_MSB:0]} :
                anchor + {6'h00, edge_cfg[gi][`PDCT_OFS_MSB:0]};
            assign edge_hit[gi] = (cur == edge_pos[gi]);
        end
    endgenerate

    // register read mux
    always @* begin
        rd_nxt = 32'h00000000;
        hit_nxt = 1'b1;
        case (paddr_i)
            `PDCT_ADDR_PWR_DLY: rd_nxt = {27'h0, pwr_dly_r};
            `PDCT_ADDR_GCK_DLY: rd_nxt = {27'h0, gck_dly_r};
            `PDCT_ADDR_LAT_W: rd_nxt = {26'h0, lat_w_r};
            `PDCT_ADDR_GCK_RISE: rd_nxt = {24'h0, gck_rise_r};
            `PDCT_ADDR_GCK_FALL: rd_nxt = {24'h0, gck_fall_r};
            `PDCT_ADDR_OE_FIRST: rd_nxt = {24'h0, oe_first_r};
            `PDCT_ADDR_OE_SECOND: rd_nxt = {24'h0, oe_second_r};
            `PDCT_ADDR_FMT2: rd_nxt = fmt_word;
            `PDCT_ADDR_LINE_LEN: rd_nxt = {20'h0, line_len_r};
            `PDCT_ADDR_STATUS: rd_nxt = status_word;
            default: hit_nxt = 1'b0;
        endcase
    end

    // apb slave: answers one cycle after setup, pready then drops
    always @* begin
        ready_nxt = setup;
        slverr_nxt = setup & ~hit_nxt;
        prdata_nxt = prdata_o;
        if (setup) begin
            prdata_nxt = pwrite_i ? 32'h00000000 : rd_nxt;
        end
    end
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o <= prdata_nxt;
            pready_o <= ready_nxt;
            pslverr_o <= slverr_nxt;
        end
    end

    // register write decode; reserved bits are dropped here
    always @* begin
        pwr_dly_nxt = pwr_dly_r;
        gck_dly_nxt = gck_dly_r;
        lat_w_nxt = lat_w_r;
        gck_rise_nxt = gck_rise_r;
        gck_fall_nxt = gck_fall_r;
        oe_first_nxt = oe_first_r;
        oe_second_nxt = oe_second_r;
        oe_pol_nxt = oe_pol_r;
        line_len_nxt = line_len_r;
        tres_div_nxt = tres_div_r;
        if (wr) begin
            case (paddr_i)
                `PDCT_ADDR_PWR_DLY: pwr_dly_nxt = pwdata_i[`PDCT_DLY_MSB:0];
                `PDCT_ADDR_GCK_DLY: gck_dly_nxt = pwdata_i[`PDCT_DLY_MSB:0];
                `PDCT_ADDR_LAT_W: lat_w_nxt = pwdata_i[`PDCT_LAT_MSB:0];
                `PDCT_ADDR_GCK_RISE: gck_rise_nxt = pwdata_i[`PDCT_EDGE_MSB:0];
                `PDCT_ADDR_GCK_FALL: gck_fall_nxt = pwdata_i[`PDCT_EDGE_MSB:0];
                `PDCT_ADDR_OE_FIRST: oe_first_nxt = pwdata_i[`PDCT_EDGE_MSB:0];
                `PDCT_ADDR_OE_SECOND: oe_second_nxt = pwdata_i[`PDCT_EDGE_MSB:0];
                `PDCT_ADDR_FMT2: begin
                    oe_pol_nxt = pwdata_i[`PDCT_POL_BIT];
                    tres_div_nxt = pwdata_i[`PDCT_DIV_MSB:`PDCT_DIV_LSB];
                end
                `PDCT_ADDR_LINE_LEN: line_len_nxt = pwdata_i[`PDCT_LEN_MSB:0];
                default: pwr_dly_nxt = pwr_dly_r;
            endcase
        end
    end

    // delay and width registers; reset values are the built-in default set
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_dly_r <= `PDCT_RST_PWR_DLY;
            gck_dly_r <= `PDCT_RST_GCK_DLY;
            lat_w_r <= `PDCT_RST_LAT_W;
        end else begin
            pwr_dly_r <= pwr_dly_nxt;
            gck_dly_r <= gck_dly_nxt;
            lat_w_r <= lat_w_nxt;
        end
    end
    // edge registers keep all eight bits, bit 7 picks the side of the latch edge
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gck_rise_r <= `PDCT_RST_GCK_RISE;
            gck_fall_r <= `PDCT_RST_GCK_FALL;
            oe_first_r <= `PDCT_RST_OE_FIRST;
            oe_second_r <= `PDCT_RST_OE_SECOND;
        end else begin
            gck_rise_r <= gck_rise_nxt;
            gck_fall_r <= gck_fall_nxt;
            oe_first_r <= oe_first_nxt;
            oe_second_r <= oe_second_nxt;
        end
    end
    // format and line length registers
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_pol_r <= `PDCT_RST_FMT2;
            line_len_r <= `PDCT_RST_LINE_LEN;
            tres_div_r <= `PDCT_RST_TRES_DIV;
        end else begin
            oe_pol_r <= oe_pol_nxt;
            line_len_r <= line_len_nxt;
            tres_div_r <= tres_div_nxt;
        end
    end

    // millisecond steps since reset release; saturates above the 31-step range
    always @* begin
        step_cnt_nxt = step_cnt_r;
        ms_steps_nxt = ms_steps_r;
        if (!ms_sat) begin
            if (step_end) begin
                step_cnt_nxt = 23'h000000;
                ms_steps_nxt = ms_steps_r + 6'h01;
            end else begin
                step_cnt_nxt = step_cnt_r + 23'h000001;
            end
        end
        power_step_nxt = (ms_steps_r >= {1'b0, pwr_dly_r});
        gck_run_nxt = (ms_steps_r >= {1'b0, gck_dly_r});
    end
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_cnt_r <= 23'h000000;
            ms_steps_r <= 6'h00;
        end else begin
            step_cnt_r <= step_cnt_nxt;
            ms_steps_r <= ms_steps_nxt;
        end
    end
    // level outputs of the time base
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_step_o <= 1'b0;
            gck_run_r <= 1'b0;
        end else begin
            power_step_o <= power_step_nxt;
            gck_run_r <= gck_run_nxt;
        end
    end

    // timing unit divider and line position counter
    always @* begin
        tick_nxt = 1'b0;
        tres_cnt_nxt = tres_cnt_r + 8'h01;
        pos_nxt = pos_r;
        if (unit_end) begin
            tres_cnt_nxt = 8'h00;
            tick_nxt = 1'b1;
        end
        if (tick_r) begin
            if (line_end) begin
                pos_nxt = 12'h000;
            end else begin
                pos_nxt = pos_r + 12'h001;
            end
        end
    end
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tres_cnt_r <= 8'h00;
            tick_r <= 1'b0;
            pos_r <= 12'h000;
        end else begin
            tres_cnt_r <= tres_cnt_nxt;
            tick_r <= tick_nxt;
            pos_r <= pos_nxt;
        end
    end

    // pulse outputs follow the line position, one clock after it moves; register writes can also force a level at once
    // a zero latch width gives no pulse at all, so a cleared register is quiet
    always @* begin
        latch_nxt = source_latch_pulse_o;
        if (lat_w_r == 6'h00) begin
            latch_nxt = 1'b0;
        end else if (cur == anchor) begin
            latch_nxt = 1'b1;
        end else if (cur == lat_end) begin
            latch_nxt = 1'b0;
        end
    end
    // with rise and fall on one position the rise wins
    always @* begin
        gck_nxt = gate_shift_clock_o;
        if (!gck_run_r) begin
            gck_nxt = 1'b0;
        end else if (edge_hit[0]) begin
            gck_nxt = 1'b1;
        end else if (edge_hit[1]) begin
            gck_nxt = 1'b0;
        end
    end
    always @* begin
        oe_nxt = gate_enable_o;
        if (oe_same) begin
            oe_nxt = oe_pol_r;
        end else if (edge_hit[2]) begin
            oe_nxt = ~oe_pol_r;
        end else if (edge_hit[3]) begin
            oe_nxt = oe_pol_r;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            source_latch_pulse_o <= 1'b0;
        end else begin
            source_latch_pulse_o <= latch_nxt;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_shift_clock_o <= 1'b0;
        end else begin
            gate_shift_clock_o <= gck_nxt;
        end
    end

    // enable idles at the reset polarity level until the first line
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_enable_o <= `PDCT_RST_FMT2;
        end else begin
            gate_enable_o <= oe_nxt;
        end
    end
endmodule // pdct_timing

// ---- tb/pdct_timing_props.sv ----
// port assertions for the control pulse timing block
`timescale 1ns/1ps
`include "pdct_defines.vh"
module pdct_timing_props #(parameter STEP_CYC = 10) (
    input logic mclk_i, rst_n_i, psel_i, penable_i, pwrite_i,
    input logic [7:0] paddr_i,
    input logic [31:0] pwdata_i, prdata_o,
    input logic pready_o, pslverr_o, power_step_o, source_latch_pulse_o, gate_shift_clock_o, gate_enable_o
);
    reg [31:0] cyc_r;
    reg [4:0] pwr_r;
    reg [4:0] gck_r;
    reg [5:0] lat_r;
    wire wr = psel_i && penable_i && pready_o && pwrite_i;
    // shadows follow writes at the access edge, where the block applies them
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_r <= 0;
            pwr_r <= `PDCT_RST_PWR_DLY;
            gck_r <= `PDCT_RST_GCK_DLY;
            lat_r <= `PDCT_RST_LAT_W;
        end else begin
            cyc_r <= cyc_r + 1;
            if (wr && paddr_i == `PDCT_ADDR_LAT_W) lat_r <= pwdata_i[5:0];
            if (wr && paddr_i == `PDCT_ADDR_PWR_DLY) pwr_r <= pwdata_i[4:0];
            if (wr && paddr_i == `PDCT_ADDR_GCK_DLY) gck_r <= pwdata_i[4:0];
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // slack of two cycles covers the step counter lag, a whole step is still caught
    AST_READY_AFTER_SETUP: assert property (psel_i && !penable_i |=> pready_o) else $error("ready missing");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o) else $error("ready too long");
    AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    AST_UNMAPPED_ZERO: assert property (pslverr_o && !pwrite_i |-> prdata_o == 0) else $error("error read data");
    AST_PWR_NOT_EARLY: assert property (power_step_o |-> cyc_r + 2 >= STEP_CYC * $past(pwr_r))
        else $error("power step early");
    AST_PWR_ON_TIME: assert property ($stable(pwr_r) && cyc_r > STEP_CYC * pwr_r + 2 |-> power_step_o)
        else $error("power step late");
    AST_GCK_HELD_LOW: assert property (cyc_r + 2 < STEP_CYC * gck_r |-> !gate_shift_clock_o)
        else $error("gate clock early");
    AST_LATCH_HOLDS: assert property ($rose(source_latch_pulse_o) && lat_r > 6'h01 |=> source_latch_pulse_o)
        else $error("latch short");
endmodule // pdct_timing_props

// ---- tb/pdct_panel_model.sv ----
// panel drivers model: stamps each control edge it receives, in clocks
`timescale 1ns/1ps
module pdct_panel_model (
    input wire clk_i,
    input wire [2:0] sig_i,
    output int lines_o,
    output int n_oe_o,
    output int t_o [6]
);
    int cyc = 0;
    logic [2:0] q = 3'h0;
    // index 2i for a rise, 2i+1 for a fall of latch, gate clock, enable
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        q <= sig_i;
        for (int i = 0; i < 3; i++) if (sig_i[i] != q[i]) t_o[2*i+!sig_i[i]] <= cyc;
        if (sig_i[0] && !q[0]) lines_o <= lines_o + 1;
        if (sig_i[2] != q[2]) n_oe_o <= n_oe_o + 1;
    end
endmodule // pdct_panel_model

// ---- tb/tb_top.sv ----
// self-checking bench for the control pulse timing block
`timescale 1ns/1ps
module tb_top;
    logic mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, er;
    logic [7:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, rd;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, power_step_o, source_latch_pulse_o, gate_shift_clock_o, gate_enable_o;
    int err_count = 0, comparisons = 0, lines, n_oe, k, t[6];
    logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h3c};
    logic [7:0] wd[8] = '{8'hff, 8'he0, 8'hff, 8'hff, 8'h80, 8'h7f, 8'h7f, 8'hff};
    logic [7:0] rx[8] = '{8'h1f, 8'h00, 8'h3f, 8'hff, 8'h80, 8'h7f, 8'h7f, 8'h00};
    always #4 mclk_i = ~mclk_i;
    // short step so the millisecond delays fit the run
    pdct_timing #(.STEP_CYC(10)) pdct_timing_inst (.*);
    pdct_panel_model pdct_panel_model_inst (.clk_i(mclk_i), .lines_o(lines), .n_oe_o(n_oe), .t_o(t),
        .sig_i({gate_enable_o, gate_shift_clock_o, source_latch_pulse_o}));
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic [7:0] a, input logic [31:0] d, input logic w);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel_i <= 1;
        paddr_i <= a;
        pwdata_i <= d;
        pwrite_i <= w;
        @(posedge mclk_i);
        penable_i <= 1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
        if (n == 20) chk(0, 1);
        if (n == 20) wrap_up;
    endtask
    // waits for two more latch rises, one whole line between them, so every edge of a line is stamped
    task cfg(input logic [31:0] f, input logic [7:0] a, input logic [7:0] b);
        int n;
        apb(8'h1c, f, 1);
        apb(8'h14, {24'h0, a}, 1);
        apb(8'h18, {24'h0, b}, 1);
        n = lines + 2;
        for (int c = 0; lines < n; c++) begin
            if (c == 3000) chk(0, 1);
            if (c == 3000) wrap_up;
            @(posedge mclk_i);
        end
        repeat (20) @(posedge mclk_i);
    endtask
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1;
        for (int i = 0; i < 8; i++) begin
            apb(ra[i], {24'h0, wd[i]}, 1);
            apb(ra[i], 0, 0);
            chk(rd, {24'h0, rx[i]});
            chk(er, ra[i] == 8'h3c);
        end
        $display("register rows done");
        rst_n_i <= 0;
        @(posedge mclk_i);
        chk(gate_enable_o, 1);
        repeat (15) @(posedge mclk_i);
        rst_n_i <= 1;
        apb(8'h1c, 0, 0);
        chk(rd, 32'h801);
        apb(8'h18, 0, 0);
        chk(rd, 32'hb4);
        $display("reset values done");
        apb(8'h08, 3, 1);
        apb(8'h0c, 5, 1);
        apb(8'h10, 32'h83, 1);
        apb(8'h20, 32'h100, 1);
        cfg(32'h101, 8'h02, 8'h86);
        chk(t[1] - t[0], 3);
        chk(t[2] - t[0], 5);
        chk(t[0] - t[3], 3);
        chk(t[5] - t[0], 2);
        chk(t[0] - t[4], 6);
        cfg(32'h100, 8'h02, 8'h86);
        chk(t[4] - t[0], 2);
        chk(t[0] - t[5], 6);
        cfg(32'h100, 8'h10, 8'h10);
        k = n_oe;
        cfg(32'h100, 8'h10, 8'h10);
        chk(n_oe - k, 0);
        chk(gate_enable_o, 0);
        $display("line timing done");
        wrap_up;
    end
endmodule // tb_top
bind pdct_timing pdct_timing_props #(.STEP_CYC(STEP_CYC)) pdct_timing_props_inst (.*);
